// ### common/astc_cfg.svh
// Register offsets, field positions and reset values of the trigger block
`ifndef ASTC_CFG_SVH
`define ASTC_CFG_SVH

`define ASTC_OFF_CTRL     8'h00
`define ASTC_OFF_EXPTIME  8'h04
`define ASTC_OFF_READOUT  8'h08
`define ASTC_OFF_SWTRIG   8'h0C
`define ASTC_OFF_STATUS   8'h10
`define ASTC_OFF_FRAMES   8'h14

`define ASTC_CTRL_MODE    0
`define ASTC_CTRL_SRC     1
`define ASTC_CTRL_ACT     2
`define ASTC_CTRL_EXPM    3
`define ASTC_CTRL_ACQ     4
`define ASTC_CTRL_W       5
`define ASTC_CTRL_RST     5'h00

`define ASTC_EXPTIME_RST  24'h000100
`define ASTC_READOUT_RST  24'h000100

`define ASTC_SWTRIG_BIT   0
`define ASTC_STAT_WAIT    0
`define ASTC_STAT_EXPO    1
`define ASTC_STAT_OVT     2

`endif

// ### common/astc_pkg.sv
// Types shared by the trigger block
`default_nettype none
package astc_pkg;
    typedef enum logic [1:0] {
        ASTC_IDLE    = 2'b00,
        ASTC_WAIT    = 2'b01,
        ASTC_EXPOSE  = 2'b10,
        ASTC_READOUT = 2'b11
    } astc_state_t;
endpackage
`default_nettype wire

// ### common/astc_if.sv
// Internal carrier between the controller, edge detector and timer
`timescale 1ns/1ps
`default_nettype none
interface astc_if #(parameter int CNT_W = 24);
    logic             level;
    logic             rise;
    logic             fall;
    logic             load;
    logic [CNT_W-1:0] value;
    logic             done;
    logic             busy;
    modport edge_src (output level, output rise, output fall);
    modport timer    (input load, input value, output done, output busy);
    modport ctrl     (input level, input rise, input fall, input done, input busy,
                      output load, output value);
endinterface // astc_if
`default_nettype wire

// ### rtl/astc_edge_sync.sv
// Trigger pin synchroniser and edge detector
`timescale 1ns/1ps
`default_nettype none
module astc_edge_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    astc_if.edge_src  sig
);
    logic meta;
    logic sync;
    logic prev;

    // Two-flop synchroniser, then edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign sig.level = sync;
    assign sig.rise  = sync & ~prev;
    assign sig.fall  = ~sync & prev;

    chk_edge_single: assert property (@(posedge clk) disable iff (rst)
        (sync & ~prev) |-> $past(pin, 2) ##1 !(sync & ~prev))
        else $error("rise pulse not from synchronised pin or too long");
endmodule // astc_edge_sync
`default_nettype wire

// ### rtl/astc_exp_timer.sv
// Down-counter for exposure and readout lengths
`timescale 1ns/1ps
`default_nettype none
module astc_exp_timer #(
    parameter int CNT_W = 24
) (
    input  wire logic clk,
    input  wire logic rst,
    astc_if.timer     t
);
    logic [CNT_W-1:0] count;

    // Zero load counts as one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (t.load) begin
            count <= (t.value == '0) ? CNT_W'(1) : t.value;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign t.busy = (count != '0);
    assign t.done = (count == CNT_W'(1));

    chk_timer_load: assert property (@(posedge clk) disable iff (rst)
        (t.load && t.value > CNT_W'(1)) |=> (count == $past(t.value)) ##1 (count == $past(t.value, 2) - 1'b1))
        else $error("timer did not load or count down");
endmodule // astc_exp_timer
`default_nettype wire

// ### rtl/astc_trigger_ctrl.sv
// Acquisition start trigger controller with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "astc_cfg.svh"

module astc_trigger_ctrl
    import astc_pkg::*;
#(
    parameter int ADDR_W  = 8,
    parameter int CNT_W   = 24,
    parameter int FRAME_W = 16
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output var  logic [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              external_start_trigger_input,
    output var  logic              waiting_for_trigger,
    output var  logic              exposure_active,
    output var  logic              frame_start,
    output var  logic              overtrigger_event
);
    localparam logic [ADDR_W-1:0] A_CTRL    = ADDR_W'(`ASTC_OFF_CTRL);
    localparam logic [ADDR_W-1:0] A_EXPTIME = ADDR_W'(`ASTC_OFF_EXPTIME);
    localparam logic [ADDR_W-1:0] A_READOUT = ADDR_W'(`ASTC_OFF_READOUT);
    localparam logic [ADDR_W-1:0] A_SWTRIG  = ADDR_W'(`ASTC_OFF_SWTRIG);
    localparam logic [ADDR_W-1:0] A_STATUS  = ADDR_W'(`ASTC_OFF_STATUS);
    localparam logic [ADDR_W-1:0] A_FRAMES  = ADDR_W'(`ASTC_OFF_FRAMES);

    astc_state_t               state;
    astc_state_t               next_state;
    logic [`ASTC_CTRL_W-1:0]   ctrl;
    logic [CNT_W-1:0]          exptime;
    logic [CNT_W-1:0]          readout;
    logic [FRAME_W-1:0]        frame_count;
    logic                      ovt_sticky;
    logic                      exp_is_width;
    logic [31:0]               ctrl_merged;
    logic [31:0]               exptime_merged;
    logic [31:0]               readout_merged;
    logic                      wr_en;
    logic                      rd_setup;
    logic                      sw_pulse;
    logic                      ovt_clr;
    logic                      trig_mode;
    logic                      src_sw;
    logic                      act_fall;
    logic                      expm_width;
    logic                      acq_en;
    logic                      hw_edge;
    logic                      trig;
    logic                      accept;
    logic                      start_width;
    logic                      level_active;
    logic                      exp_end;
    logic                      ovt_evt;

    astc_if #(.CNT_W(CNT_W)) sig ();

    astc_edge_sync u_edge (
        .clk (clk),
        .rst (rst),
        .pin (external_start_trigger_input),
        .sig (sig.edge_src)
    );

    astc_exp_timer #(.CNT_W(CNT_W)) u_timer (
        .clk (clk),
        .rst (rst),
        .t   (sig.timer)
    );

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wdat,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == A_CTRL) || (a == A_EXPTIME) || (a == A_READOUT) ||
               (a == A_SWTRIG) || (a == A_STATUS) || (a == A_FRAMES);
    endfunction

    // APB handshake, zero wait states
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~is_mapped(paddr);
    assign wr_en    = psel & penable & pwrite & is_mapped(paddr);
    assign rd_setup = psel & ~penable & ~pwrite;

    assign ctrl_merged    = apply_strb(32'(ctrl), pwdata, pstrb);
    assign exptime_merged = apply_strb(32'(exptime), pwdata, pstrb);
    assign readout_merged = apply_strb(32'(readout), pwdata, pstrb);

    assign sw_pulse = wr_en & (paddr == A_SWTRIG) & pstrb[0] & pwdata[`ASTC_SWTRIG_BIT];
    assign ovt_clr  = wr_en & (paddr == A_STATUS) & pstrb[0] & pwdata[`ASTC_STAT_OVT];

    // Configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl    <= `ASTC_CTRL_RST;
            exptime <= CNT_W'(`ASTC_EXPTIME_RST);
            readout <= CNT_W'(`ASTC_READOUT_RST);
        end else if (wr_en) begin
            if (paddr == A_CTRL) begin
                ctrl <= ctrl_merged[`ASTC_CTRL_W-1:0];
            end
            if (paddr == A_EXPTIME) begin
                exptime <= exptime_merged[CNT_W-1:0];
            end
            if (paddr == A_READOUT) begin
                readout <= readout_merged[CNT_W-1:0];
            end
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= 32'h00000000;
            if (paddr == A_CTRL) begin
                prdata <= 32'(ctrl);
            end
            if (paddr == A_EXPTIME) begin
                prdata <= 32'(exptime);
            end
            if (paddr == A_READOUT) begin
                prdata <= 32'(readout);
            end
            if (paddr == A_STATUS) begin
                prdata[`ASTC_STAT_WAIT] <= (state == ASTC_WAIT);
                prdata[`ASTC_STAT_EXPO] <= (state == ASTC_EXPOSE);
                prdata[`ASTC_STAT_OVT]  <= ovt_sticky;
            end
            if (paddr == A_FRAMES) begin
                prdata <= 32'(frame_count);
            end
        end
    end

    assign trig_mode  = ctrl[`ASTC_CTRL_MODE];
    assign src_sw     = ctrl[`ASTC_CTRL_SRC];
    assign act_fall   = ctrl[`ASTC_CTRL_ACT];
    assign expm_width = ctrl[`ASTC_CTRL_EXPM];
    assign acq_en     = ctrl[`ASTC_CTRL_ACQ];

    // Trigger selection and qualification
    assign hw_edge = act_fall ? sig.fall : sig.rise;
    assign trig    = !trig_mode ? 1'b1 :
                     (src_sw ? sw_pulse : hw_edge);
    assign accept  = (state == ASTC_WAIT) & acq_en & trig;
    assign start_width  = trig_mode & ~src_sw & expm_width;
    assign level_active = act_fall ? ~sig.level : sig.level;
    assign exp_end = (state == ASTC_EXPOSE) &
                     (exp_is_width ? ~level_active : sig.done);
    assign ovt_evt = (state == ASTC_EXPOSE) & ~exp_is_width &
                     trig_mode & ~src_sw & hw_edge;

    // Timer: exposure on timed accept, readout after exposure
    assign sig.load  = (accept & ~start_width) | exp_end;
    assign sig.value = accept ? exptime : readout;

    always_comb begin
        next_state = state;
        unique case (state)
            ASTC_IDLE: begin
                if (acq_en) begin
                    next_state = ASTC_WAIT;
                end
            end
            ASTC_WAIT: begin
                if (!acq_en) begin
                    next_state = ASTC_IDLE;
                end else if (accept) begin
                    next_state = ASTC_EXPOSE;
                end
            end
            ASTC_EXPOSE: begin
                if (exp_end) begin
                    next_state = ASTC_READOUT;
                end
            end
            ASTC_READOUT: begin
                if (sig.done) begin
                    next_state = acq_en ? ASTC_WAIT : ASTC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ASTC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Exposure kind latched per frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exp_is_width <= 1'b0;
        end else if (accept) begin
            exp_is_width <= start_width;
        end
    end

    // Frame counter, one per accepted trigger
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_count <= '0;
        end else if (accept) begin
            frame_count <= frame_count + 1'b1;
        end
    end

    // Overtrigger flag, set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovt_sticky <= 1'b0;
        end else if (ovt_evt) begin
            ovt_sticky <= 1'b1;
        end else if (ovt_clr) begin
            ovt_sticky <= 1'b0;
        end
    end

    // Registered event outputs; status outputs are decoded from state below
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frame_start       <= 1'b0;
            overtrigger_event <= 1'b0;
        end else begin
            frame_start       <= accept;
            overtrigger_event <= ovt_evt;
        end
    end

    assign waiting_for_trigger = (state == ASTC_WAIT);
    assign exposure_active     = (state == ASTC_EXPOSE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_sw_start: assert property (
        (state == ASTC_WAIT && acq_en && trig_mode && src_sw && sw_pulse) |=> exposure_active ##0 frame_start)
        else $error("software trigger did not start exposure");

    chk_wait_leave: assert property (
        accept |=> !waiting_for_trigger)
        else $error("waiting status kept after accept");

    chk_wait_return: assert property (
        (state == ASTC_READOUT && sig.done && acq_en) |=> waiting_for_trigger)
        else $error("waiting status not restored");

    chk_sw_discard: assert property (
        (sw_pulse && state != ASTC_WAIT) |=> !frame_start ##0 $stable(frame_count))
        else $error("busy software trigger not discarded");

    chk_edge_select: assert property (
        (state == ASTC_WAIT && acq_en && trig_mode && !src_sw && act_fall && sig.rise) |=> !frame_start)
        else $error("wrong edge accepted");

    chk_hw_start: assert property (
        (state == ASTC_WAIT && acq_en && trig_mode && !src_sw && hw_edge) |=> exposure_active)
        else $error("hardware edge did not start frame");

    chk_hw_ignore: assert property (
        (hw_edge && state != ASTC_WAIT) |=> !frame_start)
        else $error("edge outside waiting accepted");

    chk_frame_count: assert property (
        accept |=> frame_count == $past(frame_count) + 1'b1)
        else $error("frame count not advanced");

    chk_width_hold: assert property (
        (state == ASTC_EXPOSE && exp_is_width && level_active) |=> exposure_active)
        else $error("width exposure ended while level active");

    chk_timed_end: assert property (
        (state == ASTC_EXPOSE && !exp_is_width && sig.done) |=> state == ASTC_READOUT)
        else $error("timed exposure did not end on timer");

    chk_ovt_flag: assert property (
        ovt_evt |=> overtrigger_event && ovt_sticky && !frame_start)
        else $error("overtrigger not flagged");

    chk_width_end: assert property (
        (state == ASTC_EXPOSE && exp_is_width && !level_active) |=> state == ASTC_READOUT)
        else $error("width exposure outlived level");

    chk_internal: assert property (
        (state == ASTC_WAIT && acq_en && !trig_mode) |=> exposure_active ##0 frame_start)
        else $error("internal trigger not generated");

    cov_sw_frame: cover property (accept && trig_mode && src_sw ##[1:1000] waiting_for_trigger);
    cov_overtrig: cover property (ovt_evt);
    cov_width:    cover property (accept && start_width ##[1:1000] state == ASTC_READOUT);
    cov_internal: cover property (accept && !trig_mode);
endmodule // astc_trigger_ctrl
`default_nettype wire

// ### bench/astc_trig_src.sv
// External trigger source model driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module astc_trig_src #(
    parameter int MIN_GAP = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic req_level,
    output var  logic pin
);
    int gap;

    // Follows the requested level after a clock edge, edges kept apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin <= 1'b0;
            gap <= 0;
        end else if (gap != 0) begin
            gap <= gap - 1;
        end else if (req_level !== pin) begin
            pin <= req_level;
            gap <= MIN_GAP;
        end
    end
endmodule // astc_trig_src
`default_nettype wire

// ### bench/acquisition_start_trigger_ctrl_bench.sv
// Self-checking bench for the acquisition start trigger controller
`timescale 1ns/1ps
`default_nettype none
`include "astc_cfg.svh"
module acquisition_start_trigger_ctrl_bench;
    import astc_pkg::*;
    typedef struct {logic [4:0] ctrl; int act; int frames;} astc_row_t;
    localparam int A_SW   = 0;
    localparam int A_RISE = 1;
    localparam int A_FALL = 2;
    localparam int A_SW2  = 3;

    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0;
    logic [3:0]  pstrb    = 4'h0;
    logic [3:0]  strb     = 4'hF;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        trig_req = 1'b0;
    logic        waiting;
    logic        expo;
    logic        fstart;
    logic        ovt;
    logic [31:0] rd;
    logic        err;
    int          bad_count   = 0;
    int          tests_run   = 0;
    int          frames_seen = 0;
    int          ovt_seen    = 0;
    int          cycles      = 0;
    astc_row_t   rows [9]    = '{'{5'h13, A_SW, 1}, '{5'h11, A_RISE, 1}, '{5'h11, A_FALL, 0},
                                 '{5'h15, A_RISE, 0}, '{5'h15, A_FALL, 1}, '{5'h11, A_SW, 0},
                                 '{5'h03, A_SW, 0}, '{5'h13, A_SW2, 1}, '{5'h13, A_SW, 1}};

    astc_trigger_ctrl astc_trigger_ctrl_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .external_start_trigger_input(pin),
        .waiting_for_trigger(waiting), .exposure_active(expo),
        .frame_start(fstart), .overtrigger_event(ovt)
    );

    astc_trig_src astc_trig_src_inst (.clk(clk), .rst(rst), .req_level(trig_req), .pin(pin));

    always #12.5 clk = ~clk;

    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer, entered just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Frame and overtrigger monitor, run limit
    always @(posedge clk) begin
        cycles++;
        if (fstart === 1'b1) begin
            frames_seen++;
            check("waiting at frame start", waiting, 0);
            check("exposing at frame start", expo, 1);
        end
        if (ovt === 1'b1) begin
            ovt_seen++;
        end
        if (cycles > 5000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        int f0;
        int o0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check("waiting after reset", waiting, 0);
        check("exposing after reset", expo, 0);
        apb(1'b0, `ASTC_OFF_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h0);
        check("mapped no error", err, 0);
        apb(1'b0, `ASTC_OFF_EXPTIME, 32'h0);
        check("exptime reset", rd, 32'h100);
        apb(1'b0, `ASTC_OFF_READOUT, 32'h0);
        check("readout reset", rd, 32'h100);
        apb(1'b0, `ASTC_OFF_STATUS, 32'h0);
        check("status reset", rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped error", err, 1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, `ASTC_OFF_FRAMES, 32'h55);
        apb(1'b0, `ASTC_OFF_FRAMES, 32'h0);
        check("frames read only", rd, 32'h0);
        apb(1'b1, `ASTC_OFF_EXPTIME, 32'h4);
        apb(1'b1, `ASTC_OFF_READOUT, 32'h4);
        foreach (rows[i]) begin
            f0 = frames_seen;
            o0 = ovt_seen;
            apb(1'b1, `ASTC_OFF_CTRL, {27'h0, rows[i].ctrl});
            cyc(4);
            if (rows[i].ctrl[4]) begin
                check("waiting before trigger", waiting, 1);
            end
            case (rows[i].act)
                A_SW: apb(1'b1, `ASTC_OFF_SWTRIG, 32'h1);
                A_SW2: begin
                    apb(1'b1, `ASTC_OFF_SWTRIG, 32'h1);
                    apb(1'b1, `ASTC_OFF_SWTRIG, 32'h1);
                end
                A_RISE: trig_req <= 1'b1;
                A_FALL: trig_req <= 1'b0;
                default: trig_req <= trig_req;
            endcase
            cyc(30);
            check("frames per row", frames_seen - f0, rows[i].frames);
            check("overtrigger per row", ovt_seen - o0, 0);
        end
        apb(1'b0, `ASTC_OFF_FRAMES, 32'h0);
        check("frame count", rd, frames_seen);
        // Second rising edge in the middle of a long timed exposure
        apb(1'b1, `ASTC_OFF_EXPTIME, 32'd40);
        apb(1'b1, `ASTC_OFF_CTRL, 32'h11);
        f0 = frames_seen;
        o0 = ovt_seen;
        trig_req <= 1'b1;
        cyc(10);
        trig_req <= 1'b0;
        cyc(4);
        trig_req <= 1'b1;
        cyc(60);
        check("overtrigger frames", frames_seen - f0, 1);
        check("overtrigger events", ovt_seen - o0, 1);
        apb(1'b0, `ASTC_OFF_STATUS, 32'h0);
        check("overtrigger sticky", rd[2], 1);
        check("status waiting", rd[1:0], 2'b01);
        apb(1'b1, `ASTC_OFF_STATUS, 32'h4);
        apb(1'b0, `ASTC_OFF_STATUS, 32'h0);
        check("overtrigger cleared", rd[2], 0);
        // Width exposure follows the pin level, not the timer
        apb(1'b1, `ASTC_OFF_EXPTIME, 32'h4);
        apb(1'b1, `ASTC_OFF_CTRL, 32'h19);
        trig_req <= 1'b0;
        cyc(8);
        trig_req <= 1'b1;
        cyc(20);
        check("width exposing", expo, 1);
        trig_req <= 1'b0;
        cyc(8);
        check("width ended", expo, 0);
        // Internal triggering with mode off
        apb(1'b1, `ASTC_OFF_CTRL, 32'h10);
        f0 = frames_seen;
        cyc(45);
        check("internal frames", (frames_seen - f0) >= 4, 1);
        apb(1'b1, `ASTC_OFF_CTRL, 32'h0);
        // Byte strobes: only the low byte of the exposure length changes
        strb = 4'h1;
        apb(1'b1, `ASTC_OFF_EXPTIME, 32'hABCDEF07);
        strb = 4'hF;
        apb(1'b0, `ASTC_OFF_EXPTIME, 32'h0);
        check("exptime low byte", rd, 32'h7);
        // Reset in mid-run
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        @(posedge clk);
        check("waiting after second reset", waiting, 0);
        check("exposing after second reset", expo, 0);
        apb(1'b0, `ASTC_OFF_EXPTIME, 32'h0);
        check("exptime after second reset", rd, 32'h100);
        complete_run();
    end
endmodule // acquisition_start_trigger_ctrl_bench
`default_nettype wire
